// >>> rtl/gpa_pkg.sv
// gpa_pkg: constants shared by the gpio port access block
`default_nettype none

package gpa_pkg;

    // ------------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------------
    localparam int          GPA_NPIN      = 18;
    localparam int          GPA_AW        = 14;
    localparam int          GPA_DW        = 32;
    localparam int          GPA_LANES     = 4;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [13:0] GPA_OFS_BPIN  = 14'h0000;
    localparam logic [13:0] GPA_OFS_WPIN  = 14'h1000;
    localparam logic [13:0] GPA_OFS_DIR   = 14'h2000;
    localparam logic [13:0] GPA_OFS_MASK  = 14'h2080;
    localparam logic [13:0] GPA_OFS_PORT  = 14'h2100;
    localparam logic [13:0] GPA_OFS_MVIEW = 14'h2180;
    localparam logic [13:0] GPA_OFS_SET   = 14'h2200;
    localparam logic [13:0] GPA_OFS_CLEAR = 14'h2280;
    localparam logic [13:0] GPA_OFS_TGL   = 14'h2300;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [17:0] GPA_RST_OUT   = 18'h00000;
    localparam logic [17:0] GPA_RST_DIR   = 18'h00000;
    localparam logic [17:0] GPA_RST_MASK  = 18'h00000;
    localparam logic [31:0] GPA_RST_RDATA = 32'h00000000;

endpackage : gpa_pkg

`default_nettype wire

// >>> rtl/gpa_upd_if.sv
// gpa_upd_if: output-bit update requests between decoder and output bits
`default_nettype none

interface gpa_upd_if #(
    parameter int NPIN = gpa_pkg::GPA_NPIN
);
    logic [NPIN-1:0] load_en;
    logic [NPIN-1:0] load_val;
    logic [NPIN-1:0] set_bits;
    logic [NPIN-1:0] clear_bits;
    logic [NPIN-1:0] tgl_bits;
    logic [NPIN-1:0] out_bits;

    modport ctl (
        output load_en,
        output load_val,
        output set_bits,
        output clear_bits,
        output tgl_bits,
        input  out_bits
    );

    modport bits (
        input  load_en,
        input  load_val,
        input  set_bits,
        input  clear_bits,
        input  tgl_bits,
        output out_bits
    );
endinterface : gpa_upd_if

`default_nettype wire

// >>> rtl/gpa_out_bits.sv
// gpa_out_bits: the port's stored output bits and their update logic
`default_nettype none

module gpa_out_bits #(
    parameter int NPIN = gpa_pkg::GPA_NPIN
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    gpa_upd_if.bits   upd
);

    logic [NPIN-1:0] out_r;
    logic [NPIN-1:0] out_nxt;

    // ------------------------------------------------------------------
    // next value
    // ------------------------------------------------------------------
    // only one bus write exists per cycle, so at most one of the request
    // groups is nonzero; the chain still gives a fixed order if not
    always_comb begin
        out_nxt = out_r;
        out_nxt = (out_nxt & ~upd.load_en)
                | (upd.load_val & upd.load_en);
        out_nxt = out_nxt | upd.set_bits;
        out_nxt = out_nxt & ~upd.clear_bits;
        out_nxt = out_nxt ^ upd.tgl_bits;
    end

    // ------------------------------------------------------------------
    // register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            out_r <= gpa_pkg::GPA_RST_OUT[NPIN-1:0];
        end else begin
            out_r <= out_nxt;
        end
    end

    assign upd.out_bits = out_r;

endmodule : gpa_out_bits

`default_nettype wire

// >>> rtl/gpa_port.sv
// gpa_port: register access to one general-purpose i/o port
//
// Behaviour
// - byte pin read: level in bit 0
// - word pin read: level in every bit
// - port read: all pin levels, any size
// - masked read: zero where mask bit set
// - levels readable unless pin is analog
// - reads show pin, not direction or function
// - drive pin only if gpio-routed and output
// - byte pin write: load from data lsb
// - word pin write: load OR of data
// - port write: load covered bits, ignore mask
// - masked write: load only unmasked bits
// - set view: ones set output bits
// - clear view: ones clear output bits
// - toggle view: ones invert output bits
// - set view read returns output bits
// - eighteen pins, upper bits read zero
// - clear, toggle write-only; mask resets zero
//
// Our own choices: the placing of the registers and strobed register access.
`default_nettype none

module gpa_port #(
    parameter int NPIN = gpa_pkg::GPA_NPIN
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic [gpa_pkg::GPA_AW-1:0] bus_addr,
    input  wire logic [gpa_pkg::GPA_DW-1:0] bus_wdata,
    input  wire logic [3:0]                bus_be,
    input  wire logic                      bus_wr,
    input  wire logic                      bus_rd,
    output logic      [gpa_pkg::GPA_DW-1:0] bus_rdata,
    input  wire logic [NPIN-1:0]           pin_in,
    input  wire logic [NPIN-1:0]           pin_gpio_sel,
    input  wire logic [NPIN-1:0]           pin_analog,
    output logic      [NPIN-1:0]           port_pin_n_out,
    output logic      [NPIN-1:0]           port_pin_n_oe
);

    localparam int DW = gpa_pkg::GPA_DW;
    localparam int AW = gpa_pkg::GPA_AW;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // word-aligned match of a bus address against a register offset
    function automatic logic gpa_hit(
        input logic [AW-1:0] addr,
        input logic [AW-1:0] ofs
    );
        gpa_hit = (addr[AW-1:2] == ofs[AW-1:2]);
    endfunction : gpa_hit

    // widen the byte enables to one enable per data bit
    function automatic logic [DW-1:0] gpa_lane_bits(
        input logic [3:0] be
    );
        logic [DW-1:0] m;
        m = '0;
        for (int l = 0; l < gpa_pkg::GPA_LANES; l++) begin
            m[l*8 +: 8] = {8{be[l]}};
        end
        gpa_lane_bits = m;
    endfunction : gpa_lane_bits

    // port-wide value placed in the low bits, reserved bits zero
    function automatic logic [DW-1:0] gpa_zext(
        input logic [NPIN-1:0] v
    );
        logic [DW-1:0] r;
        r = '0;
        r[NPIN-1:0] = v;
        gpa_zext = r;
    endfunction : gpa_zext

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NPIN-1:0] dir_r;
    logic [NPIN-1:0] dir_nxt;
    logic [NPIN-1:0] mask_r;
    logic [NPIN-1:0] mask_nxt;
    logic [DW-1:0]   rdata_r;
    logic [DW-1:0]   rdata_nxt;
    logic [NPIN-1:0] oe_r;
    logic [NPIN-1:0] oe_nxt;
    logic [NPIN-1:0] drv_r;
    logic [NPIN-1:0] drv_nxt;

    // ------------------------------------------------------------------
    // output bits
    // ------------------------------------------------------------------
    gpa_upd_if #(.NPIN(NPIN)) upd ();

    gpa_out_bits #(
        .NPIN (NPIN)
    ) u_out_bits (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .upd     (upd.bits)
    );

    // ------------------------------------------------------------------
    // pin level and address decode
    // ------------------------------------------------------------------
    logic [NPIN-1:0] level;
    logic [DW-1:0]   lane_m;
    logic [DW-1:0]   wdata_m;
    logic [NPIN-1:0] port_cov;
    logic            hit_dir;
    logic            hit_mask;
    logic            hit_port;
    logic            hit_mview;
    logic            hit_set;
    logic            hit_clear;
    logic            hit_tgl;
    logic [NPIN-1:0] hit_bpin;
    logic [NPIN-1:0] hit_wpin;
    logic            wr_bpin;
    logic            wr_wpin;
    logic            wpin_or;

    // analog pins read low; everything else is taken straight from the
    // pad so direction and function selection never change a read
    assign level = pin_in & ~pin_analog;

    assign lane_m   = gpa_lane_bits(bus_be);
    assign wdata_m  = bus_wdata & lane_m;
    assign port_cov = lane_m[NPIN-1:0];
    assign wpin_or  = |wdata_m;

    assign hit_dir   = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_DIR);
    assign hit_mask  = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_MASK);
    assign hit_port  = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_PORT);
    assign hit_mview = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_MVIEW);
    assign hit_set   = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_SET);
    assign hit_clear = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_CLEAR);
    assign hit_tgl   = gpa_hit(bus_addr, gpa_pkg::GPA_OFS_TGL);

    // byte pin n sits at byte offset n: four pins share a word and the
    // byte enable picks the lane; word pin n takes its own word
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin_dec
            localparam logic [AW-1:0] BOFS =
                gpa_pkg::GPA_OFS_BPIN + AW'(g);
            localparam logic [AW-1:0] WOFS =
                gpa_pkg::GPA_OFS_WPIN + AW'(4 * g);
            assign hit_bpin[g] = gpa_hit(bus_addr, BOFS) & bus_be[g % 4];
            assign hit_wpin[g] = gpa_hit(bus_addr, WOFS);
        end
    endgenerate

    assign wr_bpin = bus_wr & (|hit_bpin);
    assign wr_wpin = bus_wr & (|hit_wpin);

    // ------------------------------------------------------------------
    // write requests to the output bits
    // ------------------------------------------------------------------
    always_comb begin
        upd.load_en  = '0;
        upd.load_val = '0;
        upd.set_bits = '0;
        upd.clear_bits = '0;
        upd.tgl_bits = '0;
        if (wr_bpin || wr_wpin) begin
            for (int n = 0; n < NPIN; n++) begin
                if (hit_bpin[n]) begin
                    upd.load_en[n]  = 1'b1;
                    upd.load_val[n] = bus_wdata[(n % 4) * 8];
                end
                if (hit_wpin[n]) begin
                    upd.load_en[n]  = 1'b1;
                    upd.load_val[n] = wpin_or;
                end
            end
        end
        if (bus_wr) begin
            if (hit_port) begin
                upd.load_en  = port_cov;
                upd.load_val = wdata_m[NPIN-1:0];
            end
            if (hit_mview) begin
                upd.load_en  = port_cov & ~mask_r;
                upd.load_val = wdata_m[NPIN-1:0];
            end
            if (hit_set) begin
                upd.set_bits = wdata_m[NPIN-1:0];
            end
            if (hit_clear) begin
                upd.clear_bits = wdata_m[NPIN-1:0];
            end
            if (hit_tgl) begin
                upd.tgl_bits = wdata_m[NPIN-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers and pin drive
    // ------------------------------------------------------------------
    always_comb begin
        dir_nxt  = dir_r;
        mask_nxt = mask_r;
        if (bus_wr && hit_dir) begin
            dir_nxt = (dir_r & ~port_cov) | (wdata_m[NPIN-1:0] & port_cov);
        end
        if (bus_wr && hit_mask) begin
            mask_nxt = (mask_r & ~port_cov)
                     | (wdata_m[NPIN-1:0] & port_cov);
        end
        // a pin not routed to gpio or set as input keeps its output bit
        // but never shows it; writes then only change the stored value
        oe_nxt  = dir_nxt & pin_gpio_sel;
        drv_nxt = upd.out_bits;
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = gpa_pkg::GPA_RST_RDATA;
        if (bus_rd) begin
            for (int n = 0; n < NPIN; n++) begin
                if (hit_bpin[n]) begin
                    rdata_nxt[(n % 4) * 8 +: 8] = {7'h00, level[n]};
                end
                if (hit_wpin[n]) begin
                    rdata_nxt = {DW{level[n]}};
                end
            end
            if (hit_port) begin
                rdata_nxt = gpa_zext(level) & lane_m;
            end
            if (hit_mview) begin
                rdata_nxt = gpa_zext(level & ~mask_r) & lane_m;
            end
            if (hit_set) begin
                rdata_nxt = gpa_zext(upd.out_bits) & lane_m;
            end
            if (hit_dir) begin
                rdata_nxt = gpa_zext(dir_r) & lane_m;
            end
            if (hit_mask) begin
                rdata_nxt = gpa_zext(mask_r) & lane_m;
            end
            // clear and toggle views are write-only and read as zero,
            // as does any unmapped address
            if (hit_clear || hit_tgl) begin
                rdata_nxt = gpa_pkg::GPA_RST_RDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            dir_r   <= gpa_pkg::GPA_RST_DIR[NPIN-1:0];
            mask_r  <= gpa_pkg::GPA_RST_MASK[NPIN-1:0];
            rdata_r <= gpa_pkg::GPA_RST_RDATA;
            oe_r    <= '0;
            drv_r   <= gpa_pkg::GPA_RST_OUT[NPIN-1:0];
        end else begin
            dir_r   <= dir_nxt;
            mask_r  <= mask_nxt;
            rdata_r <= rdata_nxt;
            oe_r    <= oe_nxt;
            drv_r   <= drv_nxt;
        end
    end

    // pin side lags the output bits by one clock so that every output of
    // this module comes from a flip-flop
    assign bus_rdata      = rdata_r;
    assign port_pin_n_out = drv_r;
    assign port_pin_n_oe  = oe_r;

endmodule : gpa_port

`default_nettype wire

// >>> bench/gpa_port_properties.sv
// gpa_port_properties: port-level assertions for the gpio port block
`default_nettype none

module gpa_port_properties #(
    parameter int NPIN = gpa_pkg::GPA_NPIN
) (
    input wire logic            sys_clk,
    input wire logic            rstn,
    input wire logic [13:0]     bus_addr,
    input wire logic [31:0]     bus_wdata,
    input wire logic [3:0]      bus_be,
    input wire logic            bus_wr,
    input wire logic            bus_rd,
    input wire logic [31:0]     bus_rdata,
    input wire logic [NPIN-1:0] pin_in,
    input wire logic [NPIN-1:0] pin_gpio_sel,
    input wire logic [NPIN-1:0] pin_analog,
    input wire logic [NPIN-1:0] port_pin_n_out,
    input wire logic [NPIN-1:0] port_pin_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // helpers and assertions
    // ------------------------------------------------------------------
    // low address bits are ignored, so compare on the word
    wire logic [13:0]     wa  = {bus_addr[13:2], 2'h0};
    wire logic [NPIN-1:0] lvl = pin_in & ~pin_analog;
    wire logic [NPIN-1:0] wd  = bus_wdata[NPIN-1:0];
    wire logic            wf  = bus_wr && bus_be == 4'hF;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    property p_byte_rd;
        bus_rd && bus_addr[13:12] == 2'h0
            |=> (bus_rdata & 32'hFEFEFEFE) == '0;
    endproperty
    a_byte_rd: assert property (p_byte_rd)
        else $error("byte pin read has upper lane bits set");
    property p_word_rd;
        bus_rd && bus_addr[13:2] == 12'h403
            |=> bus_rdata == {32{$past(lvl[3])}};
    endproperty
    a_word_rd: assert property (p_word_rd)
        else $error("word pin read not a copy of the level");
    property p_port_rd;
        bus_rd && bus_be == 4'hF && wa == gpa_pkg::GPA_OFS_PORT
            |=> bus_rdata == 32'($past(lvl));
    endproperty
    a_port_rd: assert property (p_port_rd)
        else $error("port read differs from pin levels");
    property p_mview_rd;
        bus_rd && wa == gpa_pkg::GPA_OFS_MVIEW
            |=> (bus_rdata & ~32'($past(lvl))) == '0;
    endproperty
    a_mview_rd: assert property (p_mview_rd)
        else $error("masked read shows a bit not at the pins");
    property p_wo_rd;
        bus_rd && (wa == gpa_pkg::GPA_OFS_CLEAR
                   || wa == gpa_pkg::GPA_OFS_TGL)
            |=> bus_rdata == '0;
    endproperty
    a_wo_rd: assert property (p_wo_rd)
        else $error("write-only view read nonzero");
    property p_oe;
        (port_pin_n_oe & ~$past(pin_gpio_sel)) == '0;
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin driven while not routed to gpio");
    property p_tgl;
        wf && wa == gpa_pkg::GPA_OFS_TGL
            |=> ##1 port_pin_n_out == ($past(port_pin_n_out) ^ $past(wd, 2));
    endproperty
    a_tgl: assert property (p_tgl)
        else $error("toggle did not invert the written ones");
    property p_port_wr;
        wf && wa == gpa_pkg::GPA_OFS_PORT
            |=> ##1 port_pin_n_out == $past(wd, 2);
    endproperty
    a_port_wr: assert property (p_port_wr)
        else $error("port write did not load the outputs");
    c_tgl: cover property (wf && wa == gpa_pkg::GPA_OFS_TGL);
    c_mview: cover property (bus_rd && wa == gpa_pkg::GPA_OFS_MVIEW);
    c_drive: cover property ((port_pin_n_oe & port_pin_n_out) != '0);
endmodule : gpa_port_properties

bind gpa_port gpa_port_properties #(.NPIN(NPIN)) u_props (
    .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_in(pin_in),
    .pin_gpio_sel(pin_gpio_sel), .pin_analog(pin_analog),
    .port_pin_n_out(port_pin_n_out), .port_pin_n_oe(port_pin_n_oe)
);

`default_nettype wire

// >>> bench/gpio_port_access_test.sv
// gpio_port_access_test: self-checking bench for the gpio port block
`default_nettype none

module gpio_port_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // signals, clock, design and tasks
    // ------------------------------------------------------------------
    logic        sys_clk, rstn, wr, rd;
    logic [13:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  be;
    logic [17:0] pin, sel, ana, pout, oe, so, lvl;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    gpa_port dut (
        .sys_clk(sys_clk), .rstn(rstn), .bus_addr(addr),
        .bus_wdata(wdata), .bus_be(be), .bus_wr(wr), .bus_rd(rd),
        .bus_rdata(rdata), .pin_in(pin), .pin_gpio_sel(sel),
        .pin_analog(ana), .port_pin_n_out(pout), .port_pin_n_oe(oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // the run needs under 150 cycles; the ceiling leaves ample room
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // strobe stays high so writes may follow each other with no gap
    task automatic wr_t(input logic [13:0] a, input logic [31:0] d,
                        input logic [3:0] b);
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= 1'b0;
        wr    <= 1'b1;
        @(posedge sys_clk);
    endtask : wr_t

    task automatic rd_t(input logic [13:0] a, input logic [3:0] b,
                        input logic [31:0] e);
        addr <= a;
        be   <= b;
        wr   <= 1'b0;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge sys_clk);
    endtask : rd_t

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : idle

    initial begin
        int l;
        rstn  = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 14'h0;
        wdata = 32'h0;
        be    = 4'h0;
        pin   = 18'h2A5A5;
        sel   = 18'h0FFFF;
        ana   = 18'h00001;
        lvl   = 18'h2A5A4;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_t(gpa_pkg::GPA_OFS_MASK, 4'hF, 32'h0);
        rd_t(gpa_pkg::GPA_OFS_MVIEW, 4'hF, {14'h0, lvl});
        rd_t(gpa_pkg::GPA_OFS_CLEAR, 4'hF, 32'h0);
        rd_t(gpa_pkg::GPA_OFS_TGL, 4'hF, 32'h0);
        $display("test reset state done");
        rd_t(gpa_pkg::GPA_OFS_PORT, 4'hF, {14'h0, lvl});
        rd_t(gpa_pkg::GPA_OFS_PORT, 4'h2, {16'h0, lvl[15:8], 8'h0});
        for (int n = 0; n < 18; n++) begin
            l = n % 4;
            rd_t(14'(n), 4'(1 << l), 32'(lvl[n]) << (8 * l));
            rd_t(14'h1000 + 14'(4 * n), 4'hF, {32{lvl[n]}});
        end
        $display("test pin reads done");
        wr_t(gpa_pkg::GPA_OFS_PORT, 32'hFFFD2345, 4'hF);
        wr_t(gpa_pkg::GPA_OFS_PORT, 32'h000000FF, 4'h1);
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, 32'h000123FF);
        wr_t(gpa_pkg::GPA_OFS_SET, 32'h00020001, 4'hF);
        wr_t(gpa_pkg::GPA_OFS_CLEAR, 32'h00000300, 4'hF);
        wr_t(gpa_pkg::GPA_OFS_TGL, 32'h0000F00F, 4'hF);
        so = ((18'h123FF | 18'h20001) & ~18'h00300) ^ 18'h0F00F;
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, {14'h0, so});
        $display("test port and set clear toggle done");
        // byte pin 5 gets a zero lsb with the other lane bits set
        wr_t(14'h0005, 32'h0000FE00, 4'h2);
        wr_t(14'h000A, 32'h00010000, 4'h4);
        wr_t(14'h1004, 32'h80000000, 4'hF);
        wr_t(14'h1044, 32'h00000000, 4'hF);
        so[5]  = 1'b0;
        so[10] = 1'b1;
        so[1]  = 1'b1;
        so[17] = 1'b0;
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, {14'h0, so});
        $display("test single pin writes done");
        wr_t(gpa_pkg::GPA_OFS_MASK, 32'h0000FF00, 4'hF);
        rd_t(gpa_pkg::GPA_OFS_MVIEW, 4'hF, {14'h0, lvl & 18'h300FF});
        wr_t(gpa_pkg::GPA_OFS_MVIEW, 32'h00000000, 4'hF);
        so = so & 18'h0FF00;
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, {14'h0, so});
        wr_t(gpa_pkg::GPA_OFS_PORT, 32'h0002AAAA, 4'hF);
        so = 18'h2AAAA;
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, {14'h0, so});
        wr_t(14'h2380, 32'hFFFFFFFF, 4'hF);
        rd_t(14'h2380, 4'hF, 32'h0);
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, {14'h0, so});
        rd_t(gpa_pkg::GPA_OFS_CLEAR, 4'hF, 32'h0);
        $display("test masked and unmapped done");
        wr_t(gpa_pkg::GPA_OFS_DIR, 32'h0003FF0F, 4'hF);
        idle(3);
        #1 chk({14'h0, oe}, 32'h0000FF0F);
        chk({14'h0, pout}, {14'h0, so});
        @(posedge sys_clk);
        sel <= 18'h3F0F0;
        pin <= 18'h15A5A;
        idle(3);
        #1 chk({14'h0, oe}, 32'h0003F000);
        @(posedge sys_clk);
        rd_t(gpa_pkg::GPA_OFS_PORT, 4'hF, 32'h00015A5A);
        $display("test pin drive done");
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        rd_t(gpa_pkg::GPA_OFS_SET, 4'hF, 32'h0);
        rd_t(gpa_pkg::GPA_OFS_DIR, 4'hF, 32'h0);
        #1 chk({14'h0, oe}, 32'h0);
        $display("test second reset done");
        close_out();
    end
endmodule : gpio_port_access_test

`default_nettype wire
